// ===== rtl/compare_capture_register_bank.sv
// Compare and capture register bank with shared high byte holding register.
//
// Overview of operation
// - Sixteen-bit compare value checked every timer clock.
// - Counter equal to compare value signals match.
// - Compare writes go through high byte holding.
// - One holding register shared by all registers.
// - Capture low read latches high into holding.
// - Counter write suppresses next timer clock match.
// - Match flag rises cycle after equality.
module compare_capture_register_bank
	import ccr_pkg::*;
(
	input  wire logic                  clk_sys,
	input  wire logic                  rst_b,
	input  wire ccr_pkg::bus_req_t     bus,
	input  wire ccr_pkg::timer_in_t    timer [ccr_pkg::NUM_TIMERS],
	output logic [7:0]                 rd_data,
	output logic [ccr_pkg::NUM_CMP-1:0] compare_match_flag,
	output logic [ccr_pkg::NUM_CMP-1:0] compare_output_pin
);
	typedef struct packed {
		logic [7:0] temp;
		logic [7:0] rdata;
	} bank_state_t;

	bank_state_t s;
	bank_state_t next_s;

	logic [15:0]        cmp_value [NUM_CMP];
	logic [15:0]        cap_value [NUM_TIMERS];
	logic [NUM_CMP-1:0] cmp_lo_hit;
	logic [NUM_CMP-1:0] cmp_hi_hit;
	logic [NUM_TIMERS-1:0] cap_lo_hit;
	logic [NUM_TIMERS-1:0] cap_hi_hit;
	logic [15:0]        wide_value;

	// The low byte write commits both bytes, the high byte coming from the holding register.
	assign wide_value = {s.temp, bus.wdata};

	for (genvar i = 0; i < NUM_CMP; i++) begin : g_cmp
		assign cmp_lo_hit[i] = bus.addr == CMP_LO_OFS[i];
		assign cmp_hi_hit[i] = bus.addr == CMP_HI_OFS[i];
		compare_unit u_cmp (
			.clk_sys            (clk_sys),
			.rst_b              (rst_b),
			.tick               (timer[i / NUM_CH].tick),
			.count_write        (timer[i / NUM_CH].count_write),
			.timer_count_value  (timer[i / NUM_CH].timer_count_value),
			.load               (bus.wr && cmp_lo_hit[i]),
			.load_value         (wide_value),
			.compare_value_reg  (cmp_value[i]),
			.compare_match_flag (compare_match_flag[i]),
			.compare_output_pin (compare_output_pin[i])
		);
	end

	for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_cap
		assign cap_lo_hit[t] = bus.addr == CAP_LO_OFS[t];
		assign cap_hi_hit[t] = bus.addr == CAP_HI_OFS[t];
		capture_unit u_cap (
			.clk_sys           (clk_sys),
			.rst_b             (rst_b),
			.capture           (timer[t].capture),
			.timer_count_value (timer[t].timer_count_value),
			.load              (bus.wr && cap_lo_hit[t]),
			.load_value        (wide_value),
			.capture_value_reg (cap_value[t])
		);
	end

	always_comb begin
		next_s = s;
		// Any high byte write lands in the one shared holding register.
		if (bus.wr && (|cmp_hi_hit || |cap_hi_hit)) begin
			next_s.temp = bus.wdata;
		end
		if (bus.rd) begin
			next_s.rdata = RDATA_RESET;
			for (int i = 0; i < NUM_CMP; i++) begin
				if (cmp_lo_hit[i]) begin
					next_s.rdata = cmp_value[i][7:0];
				end
				if (cmp_hi_hit[i]) begin
					next_s.rdata = cmp_value[i][15:8];
				end
			end
			for (int t = 0; t < NUM_TIMERS; t++) begin
				if (cap_lo_hit[t]) begin
					next_s.rdata = cap_value[t][7:0];
					next_s.temp  = cap_value[t][15:8];
				end
				if (cap_hi_hit[t]) begin
					next_s.rdata = s.temp;
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			s <= '{temp: TEMP_RESET, rdata: RDATA_RESET};
		end else begin
			s <= next_s;
		end
	end

	assign rd_data = s.rdata;
endmodule

// ===== pkg/ccr_pkg.sv
// Package with offsets, reset values and carrier types of the compare and capture register bank.
package ccr_pkg;
	localparam int          NUM_TIMERS  = 4;
	localparam int          NUM_CH      = 3;
	localparam int          NUM_CMP     = 12;
	localparam int          ADDR_W      = 9;
	localparam logic [15:0] VALUE_RESET = 16'h0000;
	localparam logic [7:0]  TEMP_RESET  = 8'h00;
	localparam logic [7:0]  RDATA_RESET = 8'h00;
	// Capture registers, timers 1, 3, 4, 5 in that order.
	localparam logic [ADDR_W-1:0] CAP_LO_OFS [NUM_TIMERS] = '{9'h086, 9'h096, 9'h0a6, 9'h126};
	localparam logic [ADDR_W-1:0] CAP_HI_OFS [NUM_TIMERS] = '{9'h087, 9'h097, 9'h0a7, 9'h127};
	// Compare registers, channels a, b, c of timers 1, 3, 4, 5. Timer 4 b has its bytes swapped.
	localparam logic [ADDR_W-1:0] CMP_LO_OFS [NUM_CMP] = '{
		9'h088, 9'h08a, 9'h08c, 9'h098, 9'h09a, 9'h09c,
		9'h0a8, 9'h0ab, 9'h0ac, 9'h128, 9'h12a, 9'h12c};
	localparam logic [ADDR_W-1:0] CMP_HI_OFS [NUM_CMP] = '{
		9'h089, 9'h08b, 9'h08d, 9'h099, 9'h09b, 9'h09d,
		9'h0a9, 9'h0aa, 9'h0ad, 9'h129, 9'h12b, 9'h12d};

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        wdata;
	} bus_req_t;

	typedef struct packed {
		logic [15:0] timer_count_value;
		logic        tick;
		logic        count_write;
		logic        capture;
	} timer_in_t;
endpackage

// ===== rtl/compare_unit.sv
// One output compare channel: value register, match detection and pin toggle.
module compare_unit
	import ccr_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        tick,
	input  wire logic        count_write,
	input  wire logic [15:0] timer_count_value,
	input  wire logic        load,
	input  wire logic [15:0] load_value,
	output logic      [15:0] compare_value_reg,
	output logic             compare_match_flag,
	output logic             compare_output_pin
);
	typedef struct packed {
		logic [15:0] value;
		logic        blocked;
		logic        match;
		logic        pin;
	} cmp_state_t;

	cmp_state_t s;
	cmp_state_t next_s;

	always_comb begin
		next_s = s;
		next_s.match = 1'b0;
		if (load) begin
			next_s.value = load_value;
		end
		// A counter write blocks the match on the next timer clock only.
		if (count_write) begin
			next_s.blocked = 1'b1;
		end else if (tick) begin
			next_s.blocked = 1'b0;
		end
		if (tick && !s.blocked && !count_write && timer_count_value == s.value) begin
			next_s.match = 1'b1;
			next_s.pin   = ~s.pin;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			s <= '{value: VALUE_RESET, blocked: 1'b0, match: 1'b0, pin: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign compare_value_reg  = s.value;
	assign compare_match_flag = s.match;
	assign compare_output_pin = s.pin;
endmodule

// ===== rtl/capture_unit.sv
// One input capture register, loaded by a capture event or by the processor.
module capture_unit
	import ccr_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        capture,
	input  wire logic [15:0] timer_count_value,
	input  wire logic        load,
	input  wire logic [15:0] load_value,
	output logic      [15:0] capture_value_reg
);
	typedef struct packed {
		logic [15:0] value;
	} cap_state_t;

	cap_state_t s;
	cap_state_t next_s;

	// A capture event wins over a processor write in the same cycle, so no event is lost.
	always_comb begin
		next_s = s;
		if (capture) begin
			next_s.value = timer_count_value;
		end else if (load) begin
			next_s.value = load_value;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			s <= '{value: VALUE_RESET};
		end else begin
			s <= next_s;
		end
	end

	assign capture_value_reg = s.value;
endmodule

// ===== bench/ccr_assertions.sv
// Checker for the compare and capture register bank ports.
module ccr_checker
	import ccr_pkg::*;
(
	input wire logic                   clk_sys,
	input wire logic                   rst_b,
	input wire ccr_pkg::bus_req_t      bus,
	input wire ccr_pkg::timer_in_t     timer [ccr_pkg::NUM_TIMERS],
	input wire logic [7:0]             rd_data,
	input wire logic [ccr_pkg::NUM_CMP-1:0] compare_match_flag,
	input wire logic [ccr_pkg::NUM_CMP-1:0] compare_output_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic blk0;

	// Tracks a counter write on timer 1 that has not yet been followed by a timer clock.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			blk0 <= 1'b0;
		end else if (timer[0].count_write) begin
			blk0 <= 1'b1;
		end else if (timer[0].tick) begin
			blk0 <= 1'b0;
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	tick_block_a: assert property (blk0 |=> compare_match_flag[2:0] == 3'h0)
		else $error("match on the timer clock after a counter write");
	pin_toggle_a: assert property (
		(compare_output_pin ^ $past(compare_output_pin)) == compare_match_flag)
		else $error("pin change differs from match flag");
	flag_cause_a: assert property (
		|compare_match_flag[2:0] |-> $past(timer[0].tick && !timer[0].count_write))
		else $error("match flag without a timer clock");
	write_block_a: assert property (
		$past(timer[0].count_write) |-> compare_match_flag[2:0] == 3'h0)
		else $error("match after counter write");
	no_tick_a: assert property (!timer[1].tick |=> compare_match_flag[5:3] == 3'h0)
		else $error("match without a timer clock");
	rd_hold_a: assert property (!$past(bus.rd) |-> $stable(rd_data))
		else $error("read data moved without a read");
endmodule

bind compare_capture_register_bank ccr_checker checker_u (.clk_sys, .rst_b, .bus, .timer,
	.rd_data, .compare_match_flag, .compare_output_pin);

// ===== bench/cpu_model.sv
// Processor core model making byte accesses on the register bus.
module cpu_model
	import ccr_pkg::*;
(
	input  wire logic          clk_sys,
	output ccr_pkg::bus_req_t  bus
);
	timeunit 1ns;
	timeprecision 1ps;
	initial bus = '0;
	// Address and data are inverted once released so stale values never look valid.
	task automatic acc(input logic w, input logic [8:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		bus = '{w, !w, a, d};
		@(negedge clk_sys);
		bus = '{1'b0, 1'b0, ~a, ~d};
	endtask
	task automatic wr16(input logic [8:0] hi, input logic [8:0] lo, input logic [15:0] v);
		acc(1'b1, hi, v[15:8]);
		acc(1'b1, lo, v[7:0]);
	endtask
endmodule

// ===== bench/testbench.sv
// Self-checking bench for the compare and capture register bank.
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin n_fail++; \
	$display("[ERR] %s exp %h got %h", n, e, s); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import ccr_pkg::*;
	logic               clk_sys = 1'b0;
	logic               rst_b = 1'b0;
	bus_req_t           bus;
	timer_in_t          tmr [NUM_TIMERS];
	logic [7:0]         rd_data;
	logic [NUM_CMP-1:0] flag;
	logic [NUM_CMP-1:0] pin;
	logic [15:0]        v;
	logic [15:0]        w;
	int                 n_fail = 0;
	int                 num_checks = 0;
	int                 cyc = 0;
	always #4 clk_sys = ~clk_sys;
	compare_capture_register_bank dut_u (.clk_sys, .rst_b, .bus, .timer(tmr), .rd_data,
		.compare_match_flag(flag), .compare_output_pin(pin));
	cpu_model cpu_u (.clk_sys, .bus);
	function automatic logic [NUM_CMP-1:0] ones(int i);
		return NUM_CMP'((1 << (i + 1)) - 1);
	endfunction
	task automatic give_verdict;
		if (n_fail == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			give_verdict;
		end
	end
	// Strobes last one cycle; the count stays so a late sample still sees it.
	task automatic drive(int t, logic [15:0] c, logic tk, logic cw, logic cp);
		@(negedge clk_sys);
		tmr[t] = '{c, tk, cw, cp};
		@(negedge clk_sys);
		tmr[t] = '{c, 1'b0, 1'b0, 1'b0};
	endtask
	task automatic rd16(logic [8:0] lo, logic [8:0] hi, output logic [15:0] r);
		cpu_u.acc(1'b0, lo, 8'h00);
		r[7:0] = rd_data;
		cpu_u.acc(1'b0, hi, 8'h00);
		r[15:8] = rd_data;
	endtask
	initial begin
		foreach (tmr[i]) tmr[i] = '0;
		void'($urandom(32'hb85a));
		repeat (6) @(negedge clk_sys);
		rst_b = 1'b1;
		for (int i = 0; i < NUM_CMP; i++) begin
			rd16(CMP_LO_OFS[i], CMP_HI_OFS[i], w);
			`CHK("reset", VALUE_RESET, w)
			v = 16'($urandom);
			cpu_u.wr16(CMP_HI_OFS[i], CMP_LO_OFS[i], v);
			rd16(CMP_LO_OFS[i], CMP_HI_OFS[i], w);
			`CHK("compare", v, w)
			drive(i / 3, v ^ 16'h8000, 1'b1, 1'b0, 1'b0);
			`CHK("miss", 12'h000, flag)
			drive(i / 3, v, 1'b1, 1'b0, 1'b0);
			`CHK("flag", 12'h001 << i, flag)
			`CHK("pin", ones(i), pin)
		end
		cpu_u.wr16(CMP_HI_OFS[0], CMP_LO_OFS[0], 16'hffff);
		drive(0, 16'hffff, 1'b0, 1'b1, 1'b0);
		drive(0, 16'hffff, 1'b1, 1'b0, 1'b0);
		`CHK("blocked", 12'h000, flag)
		drive(0, 16'hffff, 1'b1, 1'b0, 1'b0);
		`CHK("unblocked", 12'h001, flag)
		cpu_u.acc(1'b1, CMP_HI_OFS[1], 8'hab);
		cpu_u.acc(1'b1, CMP_HI_OFS[2], 8'hcd);
		cpu_u.acc(1'b1, CMP_LO_OFS[1], 8'h12);
		rd16(CMP_LO_OFS[1], CMP_HI_OFS[1], w);
		`CHK("shared", 16'hcd12, w)
		for (int t = 0; t < NUM_TIMERS; t++) begin
			v = 16'($urandom);
			drive(t, v, 1'b0, 1'b0, 1'b1);
			cpu_u.acc(1'b0, CAP_LO_OFS[t], 8'h00);
			w[7:0] = rd_data;
			drive(t, ~v, 1'b0, 1'b0, 1'b1);
			cpu_u.acc(1'b0, CAP_HI_OFS[t], 8'h00);
			w[15:8] = rd_data;
			`CHK("capture", v, w)
		end
		// A processor write to a capture register also goes through the holding register.
		cpu_u.wr16(CAP_HI_OFS[0], CAP_LO_OFS[0], 16'h5aa5);
		rd16(CAP_LO_OFS[0], CAP_HI_OFS[0], w);
		`CHK("cap_write", 16'h5aa5, w)
		give_verdict;
	end
endmodule
